// file: core/serial_port.v
// Second serial port: asynchronous receiver with address detect and synchronous master mode.
// Assumes an APB master on CLK and a remote serial node on the receive and transmit pins.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "serial_port_consts.vh"

module serial_port (
  input wire CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`SP_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire RX_PIN_IN,
  output wire RX_PIN_OUT,
  output wire RX_PIN_OE,
  output wire TX_PIN_OUT,
  output wire TX_PIN_OE,
  output wire RX_INT_REQ,
  output wire TX_INT_REQ,
  output wire RX_INT_PRIO,
  output wire TX_INT_PRIO
);

  localparam R_IDLE = 2'h0;
  localparam R_START = 2'h1;
  localparam R_DATA = 2'h2;
  localparam R_STOP = 2'h3;
  localparam S_IDLE = 2'h0;
  localparam S_TX = 2'h1;
  localparam S_RX = 2'h2;

  reg [7:0] enables_reg;
  reg [7:0] prios_reg;
  reg [7:0] rcsta_reg;
  reg [7:0] txsta_reg;
  reg [7:0] brg_reg;
  reg [7:0] rcbuf_reg;
  reg [7:0] txbuf_reg;
  reg rcif_reg;
  reg txif_reg;
  reg framing_error_reg;
  reg overrun_error_reg;
  reg received_ninth_bit_reg;
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg [9:0] div_reg;
  reg [1:0] rstate_reg;
  reg [3:0] os_reg;
  reg [3:0] rbits_reg;
  reg [8:0] rsh_reg;
  reg [1:0] sstate_reg;
  reg [3:0] sbits_reg;
  reg [8:0] tsh_reg;
  reg ck_reg;
  reg dt_reg;
  reg done_reg;
  reg done_framing_error_reg;
  reg [8:0] done_word_reg;

  wire port_en = rcsta_reg[`SP_BIT_PORT_EN];
  wire rx9 = rcsta_reg[`SP_BIT_RX9];
  wire single_receive_enable = rcsta_reg[`SP_BIT_SINGLE_RECEIVE_ENABLE];
  wire continuous_receive_enable = rcsta_reg[`SP_BIT_CONTINUOUS_RECEIVE_ENABLE];
  wire address_detect_enable = rcsta_reg[`SP_BIT_ADDRESS_DETECT_ENABLE];
  wire clock_source_master_select = txsta_reg[`SP_BIT_CLOCK_SOURCE_MASTER_SELECT];
  wire tx9 = txsta_reg[`SP_BIT_TX9];
  wire transmit_enable = txsta_reg[`SP_BIT_TRANSMIT_ENABLE];
  wire sync_mode = txsta_reg[`SP_BIT_SYNC];
  wire high_speed_baud_select = txsta_reg[`SP_BIT_HIGH_SPEED_BAUD_SELECT];
  wire async_on = port_en & ~sync_mode;
  wire master_on = port_en & sync_mode & clock_source_master_select;
  wire [3:0] nbits = rx9 ? 4'h9 : 4'h8;
  wire [3:0] tbits = tx9 ? 4'h9 : 4'h8;
  wire shifter_empty_status = (sstate_reg != S_TX);

  wire setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire mapped = (PADDR[1:0] == 2'h0) && (PADDR <= `SP_OFF_TXBUF);
  wire wr_rcsta = wr & (PADDR == `SP_OFF_RCSTA);
  wire wr_txbuf = wr & (PADDR == `SP_OFF_TXBUF);
  wire rd_rcbuf = rd & (PADDR == `SP_OFF_RCBUF);
  reg txbuf_full_reg;

  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~mapped;

  // The base tick feeds both the oversampler and the shift clock phases.
  wire [9:0] reload = high_speed_baud_select ? {2'h0, brg_reg} : {brg_reg, 2'h3};
  wire tick = (div_reg == 10'h000);

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg <= 10'h000;
    end else if (!port_en || tick) begin
      div_reg <= reload;
    end else begin
      div_reg <= div_reg - 10'h001;
    end
  end

  // Two stages on the pin; only the second stage is read by the receivers.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= RX_PIN_IN;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Asynchronous receiver; the start bit is checked at its middle to reject glitches.
  wire arx_done = async_on & tick & (rstate_reg == R_STOP) & (os_reg == 4'hf);
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rstate_reg <= R_IDLE;
      os_reg <= 4'h0;
      rbits_reg <= 4'h0;
      rsh_reg <= 9'h000;
    end else if (!async_on || !continuous_receive_enable) begin
      rstate_reg <= R_IDLE;
    end else if (tick) begin
      os_reg <= os_reg + 4'h1;
      case (rstate_reg)
        R_IDLE: begin
          os_reg <= 4'h0;
          if (!rx_sync_reg) begin
            rstate_reg <= R_START;
          end
        end
        R_START: begin
          if (os_reg == `SP_HALF_BIT) begin
            os_reg <= 4'h0;
            rbits_reg <= nbits;
            rstate_reg <= rx_sync_reg ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (os_reg == 4'hf) begin
            rsh_reg <= {rx_sync_reg, rsh_reg[8:1]};
            rbits_reg <= rbits_reg - 4'h1;
            if (rbits_reg == 4'h1) begin
              rstate_reg <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (os_reg == 4'hf) begin
            rstate_reg <= R_IDLE;
          end
        end
        default: begin
          rstate_reg <= R_IDLE;
        end
      endcase
    end
  end

  // Synchronous master engine; the clock idles low and data moves on its falling edge.
  wire rx_req = single_receive_enable | continuous_receive_enable;
  wire tx_load = master_on & transmit_enable & txbuf_full_reg & ~wr_txbuf & (sstate_reg == S_IDLE);
  wire srx_done = tick & (sstate_reg == S_RX) & ck_reg & (sbits_reg == 4'h1);
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sstate_reg <= S_IDLE;
      sbits_reg <= 4'h0;
      tsh_reg <= 9'h000;
      ck_reg <= 1'b0;
      dt_reg <= 1'b1;
    end else if (!master_on) begin
      sstate_reg <= S_IDLE;
      ck_reg <= 1'b0;
    end else begin
      case (sstate_reg)
        S_IDLE: begin
          ck_reg <= 1'b0;
          if (tx_load) begin
            tsh_reg <= {1'b0, txsta_reg[`SP_BIT_TRANSMIT_NINTH_BIT], txbuf_reg[7:1]};
            dt_reg <= txbuf_reg[0];
            sbits_reg <= tbits;
            sstate_reg <= S_TX;
          end else if (rx_req && !txbuf_full_reg) begin
            sbits_reg <= nbits;
            sstate_reg <= S_RX;
          end
        end
        S_TX: begin
          if (tick) begin
            ck_reg <= ~ck_reg;
            if (ck_reg) begin
              sbits_reg <= sbits_reg - 4'h1;
              dt_reg <= tsh_reg[0];
              tsh_reg <= {1'b0, tsh_reg[8:1]};
              if (sbits_reg == 4'h1) begin
                sstate_reg <= S_IDLE;
              end
            end
          end
        end
        S_RX: begin
          if (!rx_req) begin
            sstate_reg <= S_IDLE;
            ck_reg <= 1'b0;
          end else if (tick) begin
            ck_reg <= ~ck_reg;
            if (ck_reg) begin
              sbits_reg <= sbits_reg - 4'h1;
              if (sbits_reg == 4'h1) begin
                sstate_reg <= S_IDLE;
              end
            end
          end
        end
        default: begin
          sstate_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Synchronous receive shifting shares the receive shifter idea but keeps its own word.
  reg [8:0] ssh_reg;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ssh_reg <= 9'h000;
    end else if (tick && sstate_reg == S_RX && ck_reg) begin
      ssh_reg <= {rx_sync_reg, ssh_reg[8:1]};
    end
  end

  // One completion pulse for both receivers, with the word aligned to bit 0.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_reg <= 1'b0;
      done_framing_error_reg <= 1'b0;
      done_word_reg <= 9'h000;
    end else begin
      done_reg <= arx_done | srx_done;
      done_framing_error_reg <= arx_done & ~rx_sync_reg;
      if (arx_done) begin
        done_word_reg <= rx9 ? rsh_reg : {1'b0, rsh_reg[8:1]};
      end else if (srx_done) begin
        done_word_reg <= rx9 ? {rx_sync_reg, ssh_reg[8:1]} : {1'b0, rx_sync_reg, ssh_reg[8:2]};
      end
    end
  end

  wire addr_reject = address_detect_enable & rx9 & ~done_word_reg[8];
  wire rx_accept = done_reg & ~addr_reject & ~overrun_error_reg;
  wire rx_overrun = rx_accept & rcif_reg & ~rd_rcbuf;

  // Registers and their side effects; hardware sets win over software clears.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      enables_reg <= `SP_RST_BYTE;
      prios_reg <= `SP_RST_BYTE;
      rcsta_reg <= `SP_RST_BYTE;
      txsta_reg <= `SP_RST_BYTE;
      brg_reg <= `SP_RST_BYTE;
      rcbuf_reg <= `SP_RST_BYTE;
      txbuf_reg <= `SP_RST_BYTE;
      txbuf_full_reg <= 1'b0;
      rcif_reg <= 1'b0;
      txif_reg <= `SP_RST_TXIF;
      framing_error_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
      received_ninth_bit_reg <= 1'b0;
    end else begin
      if (wr && PADDR == `SP_OFF_ENABLES) begin
        enables_reg <= PWDATA[7:0];
      end
      if (wr && PADDR == `SP_OFF_PRIOS) begin
        prios_reg <= PWDATA[7:0];
      end
      if (wr && PADDR == `SP_OFF_TXSTA) begin
        txsta_reg <= PWDATA[7:0];
      end
      if (wr && PADDR == `SP_OFF_BRG) begin
        brg_reg <= PWDATA[7:0];
      end
      if (wr_rcsta) begin
        rcsta_reg <= PWDATA[7:0];
      end else if (srx_done && single_receive_enable && !continuous_receive_enable) begin
        rcsta_reg[`SP_BIT_SINGLE_RECEIVE_ENABLE] <= 1'b0;
      end
      if (wr_txbuf) begin
        txbuf_reg <= PWDATA[7:0];
        txbuf_full_reg <= 1'b1;
        txif_reg <= 1'b0;
      end else if (tx_load) begin
        txbuf_full_reg <= 1'b0;
        txif_reg <= 1'b1;
      end
      if (rd_rcbuf) begin
        rcif_reg <= 1'b0;
      end
      if (wr_rcsta && !PWDATA[`SP_BIT_CONTINUOUS_RECEIVE_ENABLE]) begin
        overrun_error_reg <= 1'b0;
        framing_error_reg <= 1'b0;
      end
      if (rx_accept && !rx_overrun) begin
        rcbuf_reg <= done_word_reg[7:0];
        received_ninth_bit_reg <= done_word_reg[8];
        framing_error_reg <= done_framing_error_reg;
        rcif_reg <= 1'b1;
      end
      if (rx_overrun) begin
        overrun_error_reg <= 1'b1;
      end
    end
  end

  // Read data is captured in the setup phase so it stands from a flip-flop.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (setup) begin
      case (PADDR)
        `SP_OFF_FLAGS: PRDATA <= {26'h0, rcif_reg, txif_reg, 4'h0};
        `SP_OFF_ENABLES: PRDATA <= {26'h0, enables_reg[5:4], 4'h0};
        `SP_OFF_PRIOS: PRDATA <= {26'h0, prios_reg[5:4], 4'h0};
        `SP_OFF_RCSTA: PRDATA <= {24'h0, rcsta_reg[7:3], framing_error_reg, overrun_error_reg, received_ninth_bit_reg};
        `SP_OFF_RCBUF: PRDATA <= {24'h0, rcbuf_reg};
        `SP_OFF_TXSTA: PRDATA <= {24'h0, txsta_reg[7:4], 1'b0, high_speed_baud_select, shifter_empty_status, txsta_reg[0]};
        `SP_OFF_BRG: PRDATA <= {24'h0, brg_reg};
        `SP_OFF_TXBUF: PRDATA <= {24'h0, txbuf_reg};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  assign RX_INT_REQ = rcif_reg & enables_reg[`SP_BIT_RCIF];
  assign TX_INT_REQ = txif_reg & enables_reg[`SP_BIT_TXIF];
  assign RX_INT_PRIO = prios_reg[`SP_BIT_RCIF];
  assign TX_INT_PRIO = prios_reg[`SP_BIT_TXIF];

  // In master mode the transmit pin carries the clock and the receive pin the data.
  wire sync_pins = port_en & sync_mode;
  assign TX_PIN_OUT = sync_pins ? ck_reg : 1'b1;
  assign TX_PIN_OE = port_en & (~sync_mode | clock_source_master_select);
  assign RX_PIN_OUT = dt_reg;
  assign RX_PIN_OE = sync_pins & clock_source_master_select & (sstate_reg == S_TX);

endmodule

// file: core/serial_port_consts.vh
// Constants of the second serial port: register offsets, field positions and reset values.
// Assumes byte addresses on an APB bus with 32-bit data, one register per aligned word.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define SP_ADDR_W 8
`define SP_OFF_FLAGS 8'h00
`define SP_OFF_ENABLES 8'h04
`define SP_OFF_PRIOS 8'h08
`define SP_OFF_RCSTA 8'h0c
`define SP_OFF_RCBUF 8'h10
`define SP_OFF_TXSTA 8'h14
`define SP_OFF_BRG 8'h18
`define SP_OFF_TXBUF 8'h1c
`define SP_BIT_RCIF 5
`define SP_BIT_TXIF 4
`define SP_BIT_PORT_EN 7
`define SP_BIT_RX9 6
`define SP_BIT_SINGLE_RECEIVE_ENABLE 5
`define SP_BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define SP_BIT_ADDRESS_DETECT_ENABLE 3
`define SP_BIT_FRAMING_ERROR 2
`define SP_BIT_OVERRUN_ERROR 1
`define SP_BIT_RECEIVED_NINTH_BIT 0
`define SP_BIT_CLOCK_SOURCE_MASTER_SELECT 7
`define SP_BIT_TX9 6
`define SP_BIT_TRANSMIT_ENABLE 5
`define SP_BIT_SYNC 4
`define SP_BIT_HIGH_SPEED_BAUD_SELECT 2
`define SP_BIT_SHIFTER_EMPTY_STATUS 1
`define SP_BIT_TRANSMIT_NINTH_BIT 0
`define SP_RST_BYTE 8'h00
`define SP_RST_TXIF 1'b1
`define SP_OVERSAMPLE 5'h10
`define SP_HALF_BIT 4'h7
`endif

// file: sim/serial_port_properties.sv
// Checker for the serial port pins, requests and shift clock.
// Assumes a bind to serial_port and an output enable of the clock pin decoded from registers.
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_properties (
  input wire CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`SP_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire RX_PIN_IN,
  input wire RX_PIN_OUT,
  input wire RX_PIN_OE,
  input wire TX_PIN_OUT,
  input wire TX_PIN_OE,
  input wire RX_INT_REQ,
  input wire TX_INT_REQ,
  input wire RX_INT_PRIO,
  input wire TX_INT_PRIO
);
  // Shadows follow software writes only, so self-clearing bits are not relied on.
  reg [7:0] sh_reg [0:7];
  reg [10:0] cnt_reg;
  reg last_reg;
  reg sync1_reg;
  reg sync2_reg;
  integer i;
  wire wr = PSEL && PENABLE && PWRITE;
  wire [7:0] en = sh_reg[1];
  wire [7:0] rc = sh_reg[3];
  wire [7:0] tx = sh_reg[5];
  wire [10:0] tick = ({3'h0, sh_reg[6]} + 11'h1) << (tx[`SP_BIT_HIGH_SPEED_BAUD_SELECT] ? 0 : 2);
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (i = 0; i < 8; i = i + 1)
        sh_reg[i] <= 8'h00;
      cnt_reg <= 11'h0;
      last_reg <= 1'b1;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      if (wr && PADDR < 8'h20 && PADDR[1:0] == 2'b00)
        sh_reg[PADDR[4:2]] <= PWDATA[7:0];
      cnt_reg <= (TX_PIN_OUT != last_reg) ? 11'h1 : cnt_reg + 11'h1;
      last_reg <= TX_PIN_OUT;
      sync1_reg <= tx[`SP_BIT_SYNC];
      sync2_reg <= sync1_reg;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_tx_write;
    wr && PADDR == `SP_OFF_TXBUF && tx[7] && tx[5] && tx[4] && rc[7] && !RX_PIN_OE;
  endsequence
  a_tx_start: assert property (s_tx_write |-> ##[1:3] RX_PIN_OE)
    else $error("Master transmission did not start.");
  a_pin_roles: assert property (TX_PIN_OE == (rc[7] && (!tx[4] || tx[7])))
    else $error("Clock pin enable wrong for the mode.");
  a_async_idle: assert property (!tx[4] && !sync1_reg |-> TX_PIN_OUT)
    else $error("Clock pin moved in asynchronous mode.");
  a_master_clock: assert property (RX_PIN_OE |-> TX_PIN_OE && tx[7])
    else $error("Data driven without a driven clock.");
  a_rx_gate: assert property (RX_INT_REQ |-> en[5])
    else $error("Receive request without its enable.");
  a_tx_gate: assert property (TX_INT_REQ |-> en[4])
    else $error("Transmit request without its enable.");
  a_tx_flag_hold: assert property ($fell(TX_INT_REQ) |->
    $past(wr && (PADDR == `SP_OFF_TXBUF || PADDR == `SP_OFF_ENABLES)))
    else $error("Transmit request dropped without a buffer write.");
  a_high_phase: assert property (last_reg && !TX_PIN_OUT && sync2_reg |-> cnt_reg == tick)
    else $error("Shift clock high phase not one tick.");
endmodule

// file: sim/remote_node.sv
// Remote serial node: asynchronous sender and synchronous slave.
// Assumes the bench resolves the data line from the port's enable.
`timescale 1ns/1ps
module remote_node (
  input wire clk,
  input wire shift_clk,
  input wire data_in,
  input wire data_oe,
  output reg data_out
);
  parameter integer BIT_CYCLES = 64;
  reg [17:0] seen_reg = 18'h0;
  reg [15:0] word_reg = 16'hffff;
  integer i;
  initial data_out = 1'b1;
  // Start bit, data LSB first with the ninth bit last, stop bit, then idle.
  task send_async(input [8:0] w, input integer nb);
    begin
      @(posedge clk);
      data_out <= 1'b0;
      for (i = 0; i <= nb + 1; i = i + 1) begin
        repeat (BIT_CYCLES) @(posedge clk);
        data_out <= (i < nb) ? w[i] : 1'b1;
      end
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
  task load_sync(input [15:0] w);
    begin
      @(posedge clk);
      word_reg <= w;
      data_out <= w[0];
    end
  endtask
  // Master bits are taken on the rising clock, in mid-bit.
  always @(posedge shift_clk)
    if (data_oe)
      seen_reg <= {data_in, seen_reg[17:1]};
  // Reply bits move two cycles after a fall, so they settle before the next fall.
  // Past the word the line replays the word inverted rather than holding a stale bit.
  always @(negedge shift_clk)
    if (!data_oe) begin
      repeat (2) @(posedge clk);
      data_out <= word_reg[1];
      word_reg <= {~word_reg[0], word_reg[15:1]};
    end
endmodule

// file: sim/testbench.sv
// Testbench of the serial port: registers, asynchronous and synchronous master traffic.
// Assumes the node model and the checker are compiled first.
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module testbench;
  reg CLK = 1'b0;
  reg ARST_N = 1'b0;
  reg PSEL = 1'b0;
  reg PENABLE = 1'b0;
  reg PWRITE = 1'b0;
  reg [7:0] PADDR = 8'h00;
  reg [31:0] PWDATA = 32'h0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, RX_PIN_OUT, RX_PIN_OE, TX_PIN_OUT, TX_PIN_OE, node_line;
  wire RX_INT_REQ, TX_INT_REQ, RX_INT_PRIO, TX_INT_PRIO;
  wire RX_PIN_IN = RX_PIN_OE ? RX_PIN_OUT : node_line;
  integer miscompares = 0;
  integer total_checks = 0;
  integer n;
  integer i;
  reg [7:0] q;
  reg [23:0] hi;
  reg err;
  always #25 CLK = ~CLK;
  serial_port serial_port_i (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_PIN_IN(RX_PIN_IN), .RX_PIN_OUT(RX_PIN_OUT),
    .RX_PIN_OE(RX_PIN_OE), .TX_PIN_OUT(TX_PIN_OUT), .TX_PIN_OE(TX_PIN_OE),
    .RX_INT_REQ(RX_INT_REQ), .TX_INT_REQ(TX_INT_REQ), .RX_INT_PRIO(RX_INT_PRIO),
    .TX_INT_PRIO(TX_INT_PRIO));
  // Sixteen samples of four cycles make one asynchronous bit.
  remote_node #(.BIT_CYCLES(64)) remote_node_i (.clk(CLK), .shift_clk(TX_PIN_OUT),
    .data_in(RX_PIN_IN), .data_oe(RX_PIN_OE), .data_out(node_line));
  task chk(input [8*10:1] nm, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h0, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1)
        @(posedge CLK);
      q = PRDATA[7:0];
      hi = PRDATA[31:8];
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // Returning at the falling edge lets callers look at settled outputs.
      @(negedge CLK);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e, input [8*10:1] nm);
    begin
      apb(1'b0, a, 8'h00);
      chk(nm, q, e);
      chk("upper", {7'h0, |hi}, 8'h00);
      chk("slave err", {7'h0, err}, (a > `SP_OFF_TXBUF) ? 8'h01 : 8'h00);
    end
  endtask
  // The wait is bounded so a lost character is reported, not hung on.
  task wait_rx;
    begin
      for (n = 0; RX_INT_REQ !== 1'b1 && n < 3000; n = n + 1)
        @(posedge CLK);
      chk("rx wait", {7'h0, RX_INT_REQ}, 8'h01);
    end
  endtask
  initial begin
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rdc(i * 4, (i == 0) ? 8'h10 : (i == 5) ? 8'h02 : 8'h00, "reset");
    rdc(8'h20, 8'h00, "unmapped");
    apb(1'b1, `SP_OFF_FLAGS, 8'h00);
    rdc(`SP_OFF_FLAGS, 8'h10, "tx flag");
    apb(1'b1, `SP_OFF_ENABLES, 8'h30);
    chk("tx req", {7'h0, TX_INT_REQ}, 8'h01);
    apb(1'b1, `SP_OFF_PRIOS, 8'h20);
    chk("prio", {6'h0, RX_INT_PRIO, TX_INT_PRIO}, 8'h02);
    apb(1'b1, `SP_OFF_BRG, 8'h03);
    apb(1'b1, `SP_OFF_TXSTA, 8'h04);
    apb(1'b1, `SP_OFF_RCSTA, 8'h90);
    remote_node_i.send_async(9'h0a5, 8);
    wait_rx;
    rdc(`SP_OFF_RCSTA, 8'h90, "rx status");
    rdc(`SP_OFF_RCBUF, 8'ha5, "rx data");
    chk("rx req", {7'h0, RX_INT_REQ}, 8'h00);
    apb(1'b1, `SP_OFF_RCSTA, 8'hd0);
    remote_node_i.send_async(9'h15a, 9);
    wait_rx;
    rdc(`SP_OFF_RCSTA, 8'hd1, "ninth");
    rdc(`SP_OFF_RCBUF, 8'h5a, "nine data");
    apb(1'b1, `SP_OFF_RCSTA, 8'hd8);
    remote_node_i.send_async(9'h033, 9);
    rdc(`SP_OFF_FLAGS, 8'h10, "dropped");
    remote_node_i.send_async(9'h1c3, 9);
    wait_rx;
    rdc(`SP_OFF_RCBUF, 8'hc3, "address");
    apb(1'b1, `SP_OFF_RCSTA, 8'hd0);
    remote_node_i.send_async(9'h044, 9);
    wait_rx;
    rdc(`SP_OFF_RCBUF, 8'h44, "all data");
    // Low speed with a zero divisor keeps the four-cycle tick, so the node's bit time still fits.
    apb(1'b1, `SP_OFF_BRG, 8'h00);
    apb(1'b1, `SP_OFF_TXSTA, 8'h00);
    apb(1'b1, `SP_OFF_RCSTA, 8'h90);
    remote_node_i.send_async(9'h011, 8);
    remote_node_i.send_async(9'h022, 8);
    rdc(`SP_OFF_RCSTA, 8'h92, "overrun");
    rdc(`SP_OFF_RCBUF, 8'h11, "kept");
    apb(1'b1, `SP_OFF_RCSTA, 8'h80);
    rdc(`SP_OFF_RCSTA, 8'h80, "cleared");
    apb(1'b1, `SP_OFF_BRG, 8'h03);
    apb(1'b1, `SP_OFF_TXSTA, 8'hf5);
    apb(1'b1, `SP_OFF_TXBUF, 8'h3c);
    apb(1'b1, `SP_OFF_TXBUF, 8'h96);
    rdc(`SP_OFF_FLAGS, 8'h00, "tx full");
    // Two nine-bit words at eight cycles a bit, with margin.
    repeat (200) @(posedge CLK);
    rdc(`SP_OFF_TXSTA, 8'hf7, "shifter");
    rdc(`SP_OFF_FLAGS, 8'h10, "tx empty");
    chk("word one", remote_node_i.seen_reg[7:0], 8'h3c);
    chk("word two", remote_node_i.seen_reg[16:9], 8'h96);
    chk("tx ninth", {6'h0, remote_node_i.seen_reg[17], remote_node_i.seen_reg[8]}, 8'h03);
    apb(1'b1, `SP_OFF_TXSTA, 8'hb4);
    remote_node_i.load_sync(16'hff69);
    apb(1'b1, `SP_OFF_RCSTA, 8'ha0);
    wait_rx;
    rdc(`SP_OFF_RCSTA, 8'h80, "single");
    rdc(`SP_OFF_RCBUF, 8'h69, "sync data");
    repeat (200) @(posedge CLK);
    rdc(`SP_OFF_FLAGS, 8'h10, "one word");
    remote_node_i.load_sync(16'hc35a);
    apb(1'b1, `SP_OFF_RCSTA, 8'hb0);
    wait_rx;
    rdc(`SP_OFF_RCBUF, 8'h5a, "first");
    wait_rx;
    rdc(`SP_OFF_RCBUF, 8'hc3, "second");
    end_sim;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    end_sim;
  end
endmodule
bind serial_port serial_port_properties serial_port_properties_i (.CLK(CLK), .ARST_N(ARST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_PIN_IN(RX_PIN_IN),
  .RX_PIN_OUT(RX_PIN_OUT), .RX_PIN_OE(RX_PIN_OE), .TX_PIN_OUT(TX_PIN_OUT),
  .TX_PIN_OE(TX_PIN_OE), .RX_INT_REQ(RX_INT_REQ), .TX_INT_REQ(TX_INT_REQ),
  .RX_INT_PRIO(RX_INT_PRIO), .TX_INT_PRIO(TX_INT_PRIO));
